//--- scd_pkg.sv
// package: command codes, power states and timing counts of the decoder
package scd_pkg;
   // command pins as {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0] CMD_NOP  = 4'h7;
   localparam logic [3:0] CMD_RW   = 4'h5;
   localparam logic [3:0] CMD_ACT  = 4'h3;
   localparam logic [3:0] CMD_PRE  = 4'h2;
   localparam logic [3:0] CMD_MRS  = 4'h0;
   localparam logic [3:0] CMD_REF  = 4'h1;
   localparam logic [3:0] CMD_ZQ   = 4'h6;
   localparam int AP_BIT  = 10;
   localparam int BC_BIT  = 12;
   localparam int CLK_MHZ = 250;
   // burst length in beats and the clocks a burst occupies (two beats/clock)
   localparam int BL8_BEATS  = 8;
   localparam int BC4_BEATS  = 4;
   localparam int BL8_CYCLES = BL8_BEATS / 2;
   localparam int BC4_CYCLES = BC4_BEATS / 2;
   // precharge time in ns and in clocks, rounded up
   localparam int TRP_NS     = 15;
   localparam int TRP_CYCLES = (TRP_NS * CLK_MHZ + 999) / 1000;
   // self refresh exit: clocks before any command, and before writes; power-down exit clocks
   localparam int TXS_CYCLES     = 64;
   localparam int TXSWR_CYCLES   = 512;
   localparam int TXP_CYCLES     = 3;
   typedef enum logic [3:0] {
      ST_ACTIVE = 4'b0001,
      ST_PPD    = 4'b0010,
      ST_APD    = 4'b0100,
      ST_SREF   = 4'b1000
   } scd_pstate_t;
endpackage

//--- scd_timer.sv
// down counter that flags when a loaded wait has elapsed
`timescale 1ns/1ps
module scd_timer #(
   parameter int WIDTH = 10
) (
   // clock and reset
   input  wire logic             clock,
   input  wire logic             rstn,
   // load and status
   input  wire logic             load,
   input  wire logic [WIDTH-1:0] value,
   output logic                  busy
);
   logic [WIDTH-1:0] cnt_reg, cnt_next;
   initial begin
      if (WIDTH < 2) $error("scd_timer width too small");
   end
   always_comb begin
      cnt_next = cnt_reg;
      if (load) begin
         cnt_next = value;
      end else if (cnt_reg != '0) begin
         cnt_next = cnt_reg - 1'b1;
      end
   end
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end
   assign busy = (cnt_reg != '0);
endmodule

//--- scd_bank_state.sv
// open/closed flag per bank, updated by activate and precharge
`timescale 1ns/1ps
module scd_bank_state #(
   parameter int BANKS = 8,
   parameter int BA_W  = 3
) (
   // clock and reset
   input  wire logic            clock,
   input  wire logic            rstn,
   // bank events
   input  wire logic            act,
   input  wire logic            pre_one,
   input  wire logic            pre_all,
   input  wire logic [BA_W-1:0] bank,
   output logic [BANKS-1:0]     open
);
   logic [BANKS-1:0] open_reg, open_next;
   initial begin
      if (BANKS != (1 << BA_W)) $error("bank count must match bank bits");
   end
   always_comb begin
      open_next = open_reg;
      if (pre_all) begin
         open_next = '0;
      end else if (pre_one) begin
         open_next[bank] = 1'b0;
      end else if (act) begin
         open_next[bank] = 1'b1;
      end
   end
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         open_reg <= '0;
      end else begin
         open_reg <= open_next;
      end
   end
   assign open = open_reg;
endmodule

//--- scd_cmd_decoder.sv
// command and clock-enable decoder with power-state tracking
//
// Behaviour
// - decode from sampled select, strobes, clock enable
// - deselect and no-operation behave identically
// - read/write: cas low, we selects direction
// - a10 auto-precharge, a12 chop in on-the-fly
// - activate opens bank with row address
// - precharge one bank, or all with a10
// - mode register set: bank picks register
// - zq calibration, a10 long versus short
// - refresh; clock enable falling means self refresh
// - power-down entry/exit only with deselect/no-op
// - precharge power-down if banks closed or auto precharge pending, else active
// - self refresh exit seen without the clock
// - termination disabled throughout self refresh
// - reset pin acts only asynchronously
// - bursts run to completion, no-op ignored
// - idle: banks closed, no burst, timings met
`timescale 1ns/1ps
module scd_cmd_decoder #(
   parameter int BANKS = 8,
   parameter int BA_W  = 3,
   parameter int A_W   = 16
) (
   // clock and reset
   input  wire logic            clock,
   input  wire logic            rstn,
   // command bus
   input  wire logic            cke,
   input  wire logic            cs_n,
   input  wire logic            ras_n,
   input  wire logic            cas_n,
   input  wire logic            we_n,
   input  wire logic [BA_W-1:0] ba,
   input  wire logic [A_W-1:0]  addr,
   input  wire logic            odt,
   // mode configuration
   input  wire logic            bl_otf,
   input  wire logic            bl_fixed_bc4,
   // decoded command pulses
   output logic                 cmd_act,
   output logic                 cmd_rd,
   output logic                 cmd_wr,
   output logic                 cmd_pre,
   output logic                 cmd_mrs,
   output logic                 cmd_ref,
   output logic                 cmd_zq,
   output logic                 cmd_illegal,
   output logic [BA_W-1:0]      cmd_bank,
   output logic [A_W-1:0]       cmd_addr,
   output logic                 cmd_ap,
   output logic                 cmd_bc4,
   output logic                 cmd_pre_all,
   output logic                 cmd_zq_long,
   // state
   output scd_pkg::scd_pstate_t pstate,
   output logic                 burst_busy,
   output logic                 dev_idle,
   output logic                 odt_en,
   output logic                 wr_allowed
);
   initial begin
      if (A_W < 13) $error("address must reach the chop bit");
   end

   function automatic logic is_nop(input logic [3:0] c);
      return c[3] || (c == scd_pkg::CMD_NOP);
   endfunction

   // sampled pins, taken at the rising edge
   logic       cke_prev_reg;
   logic [3:0] pins;
   logic       valid_cmd;
   assign pins = {cs_n, ras_n, cas_n, we_n};
   // commands only while clock enable stayed high
   assign valid_cmd = cke_prev_reg && cke && !cs_n;

   logic d_act, d_rw, d_pre, d_mrs, d_ref, d_zq, d_sre, d_pde, d_exit;
   logic [BANKS-1:0] open_w;
   logic pre_busy, exit_busy, wr_busy, xp_busy, ap_pending_reg;
   always_comb begin
      d_act  = valid_cmd && pins == scd_pkg::CMD_ACT;
      d_rw   = valid_cmd && pins[3:1] == scd_pkg::CMD_RW[3:1];
      d_pre  = valid_cmd && pins == scd_pkg::CMD_PRE;
      d_mrs  = valid_cmd && pins == scd_pkg::CMD_MRS;
      d_ref  = valid_cmd && pins == scd_pkg::CMD_REF;
      d_zq   = valid_cmd && pins == scd_pkg::CMD_ZQ;
      d_sre  = cke_prev_reg && !cke && !cs_n
               && pins == scd_pkg::CMD_REF;
      d_pde  = cke_prev_reg && !cke && is_nop(pins);
      d_exit = !cke_prev_reg && cke && is_nop(pins);
   end

   // burst counter: a no-op never cuts a running burst short
   logic [2:0] burst_reg, burst_next;
   logic       bc4_w;
   assign bc4_w = bl_otf ? !addr[scd_pkg::BC_BIT] : bl_fixed_bc4;
   always_comb begin
      burst_next = burst_reg;
      if (d_rw && burst_reg <= 3'h1) begin
         burst_next = bc4_w ? 3'(scd_pkg::BC4_CYCLES)
                            : 3'(scd_pkg::BL8_CYCLES);
      end else if (burst_reg != 3'h0) begin
         burst_next = burst_reg - 3'h1;
      end
   end

   // power state
   scd_pkg::scd_pstate_t ps_reg, ps_next;
   logic bank_open_any, sr_async_exit, sr_exit;
   assign bank_open_any = |open_w;
   always_comb begin
      ps_next = ps_reg;
      unique case (ps_reg)
         scd_pkg::ST_ACTIVE: begin
            if (d_sre && !bank_open_any && burst_reg == 3'h0) begin
               ps_next = scd_pkg::ST_SREF;
            end else if (d_pde) begin
               // closed banks after pending precharge means precharge pd
               ps_next = (bank_open_any && !(d_pre && cmd_pre_all)
                          && !ap_pending_reg) ? scd_pkg::ST_APD
                                              : scd_pkg::ST_PPD;
            end
         end
         scd_pkg::ST_PPD, scd_pkg::ST_APD: begin
            if (d_exit) begin
               ps_next = scd_pkg::ST_ACTIVE;
            end
         end
         scd_pkg::ST_SREF: begin
            if (d_exit) begin
               ps_next = scd_pkg::ST_ACTIVE;
            end
         end
         default: ps_next = scd_pkg::ST_ACTIVE;
      endcase
   end

   // self refresh exit is caught from cke alone, no clock needed
   assign sr_async_exit = (ps_reg == scd_pkg::ST_SREF) && cke;
   // exit edge itself: the exit timers only load here, so gate directly
   assign sr_exit = (ps_reg == scd_pkg::ST_SREF) && d_exit;

   logic ap_pending_next;
   always_comb begin
      ap_pending_next = ap_pending_reg;
      if (d_rw && addr[scd_pkg::AP_BIT]) begin
         ap_pending_next = 1'b1;
      end else if (!burst_busy && !pre_busy) begin
         ap_pending_next = 1'b0;
      end
   end

   // registered outputs
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cke_prev_reg   <= 1'b0;
         burst_reg      <= 3'h0;
         ps_reg         <= scd_pkg::ST_ACTIVE;
         ap_pending_reg <= 1'b0;
         cmd_act        <= 1'b0;
         cmd_rd         <= 1'b0;
         cmd_wr         <= 1'b0;
         cmd_pre        <= 1'b0;
         cmd_mrs        <= 1'b0;
         cmd_ref        <= 1'b0;
         cmd_zq         <= 1'b0;
         cmd_illegal    <= 1'b0;
         cmd_bank       <= '0;
         cmd_addr       <= '0;
         cmd_ap         <= 1'b0;
         cmd_bc4        <= 1'b0;
         cmd_pre_all    <= 1'b0;
         cmd_zq_long    <= 1'b0;
         burst_busy     <= 1'b0;
         dev_idle       <= 1'b0;
         odt_en         <= 1'b0;
         wr_allowed     <= 1'b1;
      end else begin
         cke_prev_reg   <= cke;
         burst_reg      <= burst_next;
         ps_reg         <= ps_next;
         ap_pending_reg <= ap_pending_next;
         cmd_act        <= d_act;
         cmd_rd         <= d_rw && we_n;
         cmd_wr         <= d_rw && !we_n;
         cmd_pre        <= d_pre;
         cmd_mrs        <= d_mrs;
         cmd_ref        <= d_ref;
         cmd_zq         <= d_zq;
         // a read or write that overlaps a running burst cannot be honoured
         cmd_illegal    <= d_rw && burst_reg > 3'h1;
         cmd_bank       <= ba;
         cmd_addr       <= addr;
         cmd_ap         <= d_rw && addr[scd_pkg::AP_BIT];
         cmd_bc4        <= d_rw && bc4_w;
         cmd_pre_all    <= d_pre && addr[scd_pkg::AP_BIT];
         cmd_zq_long    <= d_zq && addr[scd_pkg::AP_BIT];
         burst_busy     <= burst_next != 3'h0;
         dev_idle       <= ps_next == scd_pkg::ST_ACTIVE && cke
                           && !bank_open_any && burst_next == 3'h0
                           && !pre_busy && !exit_busy && !xp_busy
                           && !d_exit && !d_act && !d_pre;
         odt_en         <= odt && ps_next != scd_pkg::ST_SREF
                           && !sr_async_exit;
         // closed in self refresh and on its exit edge, before the timer
         wr_allowed     <= !wr_busy && ps_next != scd_pkg::ST_SREF
                           && !sr_exit;
      end
   end
   assign pstate = ps_reg;

   // bank bookkeeping; only precharge commands close banks, auto precharge does not
   scd_bank_state #(
      .BANKS   (BANKS),
      .BA_W    (BA_W)
   ) u_banks (
      .clock   (clock),
      .rstn    (rstn),
      .act     (d_act),
      .pre_one (d_pre && !addr[scd_pkg::AP_BIT]),
      .pre_all (d_pre && addr[scd_pkg::AP_BIT]),
      .bank    (ba),
      .open    (open_w)
   );

   scd_timer #(.WIDTH(4)) u_trp (
      .clock (clock),
      .rstn  (rstn),
      .load  (d_pre),
      .value (4'(scd_pkg::TRP_CYCLES)),
      .busy  (pre_busy)
   );
   scd_timer #(.WIDTH(8)) u_txs (
      .clock (clock),
      .rstn  (rstn),
      .load  (ps_reg == scd_pkg::ST_SREF && d_exit),
      .value (8'(scd_pkg::TXS_CYCLES)),
      .busy  (exit_busy)
   );
   scd_timer #(.WIDTH(10)) u_txswr (
      .clock (clock),
      .rstn  (rstn),
      .load  (ps_reg == scd_pkg::ST_SREF && d_exit),
      .value (10'(scd_pkg::TXSWR_CYCLES)),
      .busy  (wr_busy)
   );
   scd_timer #(.WIDTH(4)) u_txp (
      .clock (clock),
      .rstn  (rstn),
      .load  (ps_reg != scd_pkg::ST_SREF && ps_reg != scd_pkg::ST_ACTIVE
              && d_exit),
      .value (4'(scd_pkg::TXP_CYCLES)),
      .busy  (xp_busy)
   );

   // checks
   property p_rd_pulse;
      @(posedge clock) disable iff (!rstn)
      (cke_prev_reg && cke && pins == 4'h5) |=> cmd_rd;
   endproperty
   a_rd_pulse: assert property (p_rd_pulse) else $error("read missed");
   property p_no_cmd_low_cke;
      @(posedge clock) disable iff (!rstn)
      !cke_prev_reg |=> !(cmd_act || cmd_rd || cmd_wr || cmd_ref);
   endproperty
   a_no_cmd_low_cke: assert property (p_no_cmd_low_cke)
      else $error("command while cke low");
   property p_sref_odt;
      @(posedge clock) disable iff (!rstn)
      pstate == scd_pkg::ST_SREF |-> !odt_en;
   endproperty
   a_sref_odt: assert property (p_sref_odt)
      else $error("odt during self refresh");
   property p_burst_len;
      @(posedge clock) disable iff (!rstn)
      (d_rw && !bc4_w && burst_reg == 3'h0) |=> burst_busy [*4];
   endproperty
   a_burst_len: assert property (p_burst_len)
      else $error("burst ended early");
   property p_pde;
      @(posedge clock) disable iff (!rstn)
      (pstate == scd_pkg::ST_ACTIVE && d_pde && !d_sre && bank_open_any
       && !ap_pending_reg) |=> pstate == scd_pkg::ST_APD;
   endproperty
   a_pde: assert property (p_pde) else $error("no active pd");
   property p_exit;
      @(posedge clock) disable iff (!rstn)
      (pstate == scd_pkg::ST_SREF && d_exit) |=> !wr_allowed [*8];
   endproperty
   a_exit: assert property (p_exit) else $error("write open early");
   property p_idle;
      @(posedge clock) disable iff (!rstn)
      dev_idle |-> !$past(bank_open_any) && open_w == '0;
   endproperty
   a_idle: assert property (p_idle) else $error("idle with open bank");
   property p_pre_all;
      @(posedge clock) disable iff (!rstn)
      cmd_pre_all |=> open_w == '0;
   endproperty
   a_pre_all: assert property (p_pre_all)
      else $error("banks open after precharge all");
   c_sref: cover property (@(posedge clock) pstate == scd_pkg::ST_SREF);
   c_apd: cover property (@(posedge clock) pstate == scd_pkg::ST_APD);
   c_wr: cover property (@(posedge clock) cmd_wr && cmd_bc4);
   property p_wr_pulse;
      @(posedge clock) disable iff (!rstn)
      (cke_prev_reg && cke && pins == 4'h4) |=> cmd_wr;
   endproperty
   a_wr_pulse: assert property (p_wr_pulse) else $error("write missed");
   property p_nop_quiet;
      @(posedge clock) disable iff (!rstn)
      (cke_prev_reg && cke && is_nop(pins)) |=> !(cmd_act || cmd_rd
         || cmd_wr || cmd_pre || cmd_mrs || cmd_ref || cmd_zq);
   endproperty
   a_nop_quiet: assert property (p_nop_quiet)
      else $error("command from no-op");
   property p_sre_refused;
      @(posedge clock) disable iff (!rstn)
      (pstate == scd_pkg::ST_ACTIVE && d_sre && bank_open_any)
         |=> pstate == scd_pkg::ST_ACTIVE;
   endproperty
   a_sre_refused: assert property (p_sre_refused)
      else $error("self refresh with open bank");
   property p_ppd;
      @(posedge clock) disable iff (!rstn)
      (pstate == scd_pkg::ST_ACTIVE && d_pde && !bank_open_any)
         |=> pstate == scd_pkg::ST_PPD;
   endproperty
   a_ppd: assert property (p_ppd) else $error("no precharge pd");
   property p_pd_exit;
      @(posedge clock) disable iff (!rstn)
      ((pstate == scd_pkg::ST_PPD || pstate == scd_pkg::ST_APD) && d_exit)
         |=> pstate == scd_pkg::ST_ACTIVE;
   endproperty
   a_pd_exit: assert property (p_pd_exit)
      else $error("power-down exit missed");
   property p_exit_idle;
      @(posedge clock) disable iff (!rstn)
      (pstate == scd_pkg::ST_SREF && d_exit) |=> !dev_idle [*8];
   endproperty
   a_exit_idle: assert property (p_exit_idle)
      else $error("idle during exit time");
   c_ppd: cover property (@(posedge clock) pstate == scd_pkg::ST_PPD);
   c_illegal: cover property (@(posedge clock) cmd_illegal);
endmodule

//--- scd_ctrl_model.sv
// behavioural memory controller that drives the command bus
`timescale 1ns/1ps
module scd_ctrl_model #(
   parameter int HOLD = 3
) (
   // clock
   input  wire logic        clock,
   // command bus
   output logic             cke,
   output logic             cs_n,
   output logic             ras_n,
   output logic             cas_n,
   output logic             we_n,
   output logic [2:0]       ba,
   output logic [15:0]      addr
);
   int held;

   initial begin
      cke = 1'b0;
      {cs_n, ras_n, cas_n, we_n} = scd_pkg::CMD_NOP;
      ba = 3'h0;
      addr = 16'h0000;
      held = 0;
   end

   // one command per falling edge, so the rising edge sees settled pins
   task automatic drive(input logic [3:0] c, input logic k,
                        input logic [2:0] b, input logic [15:0] a);
      @(negedge clock);
      held = (k === cke) ? held + 1 : 1;
      cke = k;
      {cs_n, ras_n, cas_n, we_n} = c;
      if (c[3]) begin
         // deselected lines carry no value: toggle rather than hold
         ba = ~ba;
         addr = ~addr;
      end else begin
         ba = b;
         addr = a;
      end
   endtask

   // a new clock enable level is held a minimum time before changing
   task automatic issue(input logic [3:0] c, input logic k,
                        input logic [2:0] b, input logic [15:0] a);
      while (k !== cke && held < HOLD) begin
         drive(scd_pkg::CMD_NOP, cke, ba, addr);
      end
      drive(c, k, b, a);
   endtask
endmodule

//--- tb_sdram_command_cke_decoder.sv
// self-checking bench for the command and clock-enable decoder
`timescale 1ns/1ps
module tb_sdram_command_cke_decoder;
   logic clock = 1'b0, rstn = 1'b0, odt = 1'b0;
   logic bl_otf = 1'b1, bl_fixed_bc4 = 1'b0;
   logic cke, cs_n, ras_n, cas_n, we_n;
   logic [2:0] ba, cmd_bank;
   logic [15:0] addr, cmd_addr;
   logic cmd_act, cmd_rd, cmd_wr, cmd_pre, cmd_mrs, cmd_ref, cmd_zq;
   logic cmd_illegal, cmd_ap, cmd_bc4, cmd_pre_all, cmd_zq_long;
   logic burst_busy, dev_idle, odt_en, wr_allowed;
   scd_pkg::scd_pstate_t pstate;
   int failures = 0, compares = 0, cycles = 0;
   localparam logic [3:0] CM [10] = '{scd_pkg::CMD_ACT, scd_pkg::CMD_RW,
      4'h4, scd_pkg::CMD_PRE, scd_pkg::CMD_PRE, scd_pkg::CMD_MRS,
      scd_pkg::CMD_ZQ, scd_pkg::CMD_ZQ, scd_pkg::CMD_REF, 4'h8};
   localparam logic [2:0] BA [10] = '{2, 2, 2, 2, 5, 3, 0, 0, 0, 0};
   localparam logic [15:0] AD [10] = '{16'h1234, 16'h0408, 16'h1010,
      16'h0000, 16'h0400, 16'h0a5a, 16'h0400, 16'h0000, 16'h0000, 16'h0000};
   localparam logic [7:0] EP [10] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h10,
      8'h08, 8'h02, 8'h02, 8'h04, 8'h00};
   localparam logic [3:0] EF [10] = '{0, 4'hc, 0, 0, 4'h2, 0, 4'h1, 0, 0, 0};

   always #2 clock = ~clock;

   scd_ctrl_model i_ctrl (.clock(clock), .cke(cke), .cs_n(cs_n),
      .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr));

   scd_cmd_decoder i_dut (.clock(clock), .rstn(rstn), .cke(cke),
      .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba),
      .addr(addr), .odt(odt), .bl_otf(bl_otf),
      .bl_fixed_bc4(bl_fixed_bc4), .cmd_act(cmd_act), .cmd_rd(cmd_rd),
      .cmd_wr(cmd_wr), .cmd_pre(cmd_pre), .cmd_mrs(cmd_mrs),
      .cmd_ref(cmd_ref), .cmd_zq(cmd_zq), .cmd_illegal(cmd_illegal),
      .cmd_bank(cmd_bank), .cmd_addr(cmd_addr), .cmd_ap(cmd_ap),
      .cmd_bc4(cmd_bc4), .cmd_pre_all(cmd_pre_all),
      .cmd_zq_long(cmd_zq_long), .pstate(pstate),
      .burst_busy(burst_busy), .dev_idle(dev_idle), .odt_en(odt_en),
      .wr_allowed(wr_allowed));

   task automatic chk(input string n, input logic [15:0] e,
                      input logic [15:0] g);
      compares++;
      if (g !== e) begin
         failures++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic chk_ps(input scd_pkg::scd_pstate_t e);
      chk("pstate", 16'(e), 16'(pstate));
   endtask

   task automatic chk_pulses(input logic [7:0] ep, input logic [3:0] ef);
      chk("pulses", 16'(ep), 16'({cmd_act, cmd_rd, cmd_wr, cmd_pre,
         cmd_mrs, cmd_ref, cmd_zq, cmd_illegal}));
      chk("flags", 16'(ef), 16'({cmd_ap, cmd_bc4, cmd_pre_all,
         cmd_zq_long}));
   endtask

   // nops end just after the rising edge that follows the last one
   task automatic nops(input int n, input logic k);
      repeat (n) i_ctrl.issue(scd_pkg::CMD_NOP, k, 3'h0, 16'h0000);
      @(posedge clock);
      #1;
   endtask

   // one command, then look just after the edge that samples it
   task automatic put(input logic [3:0] c, input logic k,
                      input logic [2:0] b, input logic [15:0] a);
      i_ctrl.issue(c, k, b, a);
      @(posedge clock);
      #1;
   endtask

   task automatic send(input int i);
      put(CM[i], 1'b1, BA[i], AD[i]);
      if (!CM[i][3]) chk("cmd_bank", 16'(BA[i]), 16'(cmd_bank));
      if (!CM[i][3]) chk("cmd_addr", AD[i], cmd_addr);
      chk_pulses(EP[i], EF[i]);
      nops(1, 1'b1);
   endtask

   task automatic t_decode;
      for (int i = 0; i < 10; i++) begin
         send(i);
         nops(4, 1'b1);
      end
   endtask

   task automatic t_power_down;
      i_ctrl.issue(scd_pkg::CMD_NOP, 1'b0, 3'h0, 16'h0000);
      nops(1, 1'b0);
      chk_ps(scd_pkg::ST_PPD);
      put(scd_pkg::CMD_ACT, 1'b0, 3'h1, 16'h0001);
      chk_pulses(8'h00, 4'h0);
      nops(3, 1'b1);
      chk_ps(scd_pkg::ST_ACTIVE);
      send(0);
      chk("dev_idle", 16'h0000, 16'(dev_idle));
      i_ctrl.issue(scd_pkg::CMD_NOP, 1'b0, 3'h0, 16'h0000);
      nops(1, 1'b0);
      chk_ps(scd_pkg::ST_APD);
      nops(3, 1'b1);
      // banks still open, so a self refresh request must be refused
      i_ctrl.issue(scd_pkg::CMD_REF, 1'b0, 3'h0, 16'h0000);
      nops(1, 1'b0);
      chk_ps(scd_pkg::ST_ACTIVE);
      nops(4, 1'b1);
   endtask

   task automatic t_burst;
      @(negedge clock) bl_otf = 1'b0;
      put(scd_pkg::CMD_RW, 1'b1, 3'h2, 16'h0408);
      chk_pulses(8'h40, 4'h8);
      chk("burst_busy", 16'h0001, 16'(burst_busy));
      put(scd_pkg::CMD_RW, 1'b1, 3'h2, 16'h0000);
      chk("cmd_illegal", 16'h0001, 16'(cmd_illegal));
      chk_pulses(8'h41, 4'h0);
      chk("burst_busy", 16'h0001, 16'(burst_busy));
      nops(8, 1'b1);
      chk("burst_busy", 16'h0000, 16'(burst_busy));
      @(negedge clock) bl_fixed_bc4 = 1'b1;
      put(scd_pkg::CMD_RW, 1'b1, 3'h2, 16'h1000);
      chk_pulses(8'h40, 4'h4);
      nops(6, 1'b1);
      send(4);
      nops(4, 1'b1);
   endtask

   task automatic t_self_refresh;
      @(negedge clock) odt = 1'b1;
      i_ctrl.issue(scd_pkg::CMD_REF, 1'b0, 3'h0, 16'h0000);
      nops(1, 1'b0);
      chk_ps(scd_pkg::ST_SREF);
      nops(4, 1'b0);
      chk("odt_en", 16'h0000, 16'(odt_en));
      i_ctrl.issue(scd_pkg::CMD_NOP, 1'b1, 3'h0, 16'h0000);
      nops(1, 1'b1);
      chk_ps(scd_pkg::ST_ACTIVE);
      chk("dev_idle", 16'h0000, 16'(dev_idle));
      nops(500, 1'b1);
      chk("wr_allowed", 16'h0000, 16'(wr_allowed));
      nops(20, 1'b1);
      chk("wr_allowed", 16'h0001, 16'(wr_allowed));
      chk("dev_idle", 16'h0001, 16'(dev_idle));
      chk("odt_en", 16'h0001, 16'(odt_en));
   endtask

   task automatic t_reset_mid;
      send(1);
      @(negedge clock) rstn = 1'b0;
      #1;
      chk("burst_busy", 16'h0000, 16'(burst_busy));
      chk_ps(scd_pkg::ST_ACTIVE);
      @(negedge clock) rstn = 1'b1;
      nops(2, 1'b1);
      chk_pulses(8'h00, 4'h0);
   endtask

   task automatic wrap_up;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // the whole run needs well under this many clocks
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         wrap_up();
      end
   end

   initial begin
      repeat (2) @(posedge clock);
      #1;
      chk_ps(scd_pkg::ST_ACTIVE);
      chk("wr_allowed", 16'h0001, 16'(wr_allowed));
      chk("odt_en", 16'h0000, 16'(odt_en));
      @(negedge clock) rstn = 1'b1;
      nops(2, 1'b1);
      t_decode();
      t_power_down();
      t_burst();
      t_self_refresh();
      t_reset_mid();
      wrap_up();
   end
endmodule
